// >>> design/lae_cfg.svh
// Constants for the load align and extend data path.
`ifndef LAE_CFG_SVH
`define LAE_CFG_SVH

// Instruction field positions.
`define LAE_OPC_HI 31
`define LAE_OPC_LO 26
`define LAE_BASE_HI 25
`define LAE_BASE_LO 21
`define LAE_TGT_HI 20
`define LAE_TGT_LO 16
`define LAE_IMM_HI 15
`define LAE_IMM_LO 0

// Opcodes of the supported loads.
`define LAE_OPC_HALF_SIGNED 6'h21
`define LAE_OPC_HALF_ZERO 6'h25
`define LAE_OPC_UPPER_IMM 6'h0f
`define LAE_OPC_WORD_SIGNED 6'h23
`define LAE_OPC_WORD_LEFT 6'h22
`define LAE_OPC_WORD_RIGHT 6'h26

// Transfer size codes sent to memory (bytes minus one).
`define LAE_SIZE_HALF 3'h1
`define LAE_SIZE_WORD 3'h3
`define LAE_SIZE_PART_MAX 2'h3

// Byte offsets within the doubleword.
`define LAE_OFS_TOP 3'h7
`define LAE_OFS_ZERO 3'h0

// Reset values, fill constants and merge masks.
`define LAE_ZERO64 64'h0000_0000_0000_0000
`define LAE_ZERO32 32'h0000_0000
`define LAE_ONES32 32'hffff_ffff
`define LAE_LOW24 32'h00ff_ffff
`define LAE_ZERO16 16'h0000
`define LAE_ZERO48 48'h0000_0000_0000
`define LAE_REG_ZERO 5'h00

`endif

// >>> design/lae_merge.sv
// Aligns, merges and extends returned memory data for one load.
`timescale 1ns/100ps
`include "lae_cfg.svh"

module lae_merge import lae_pkg::*; (
  // Load description.
  input wire lae_kind_t kind,
  input wire logic [2:0] dbl_byte,
  input wire logic [1:0] part_byte,
  input wire logic word_sel,
  input wire logic mode64,
  // Data.
  input wire logic [63:0] mem_rdata,
  input wire logic [63:0] old_value,
  output logic [63:0] result
);

  logic [63:0] shifted;
  logic [31:0] mem_word;
  logic [31:0] left_word;
  logic [31:0] right_word;
  logic [31:0] keep_left;
  logic [31:0] keep_right;
  logic [15:0] half;
  logic [31:0] word;

  assign shifted = mem_rdata >> {dbl_byte, 3'h0};
  assign half = shifted[15:0];
  assign word = shifted[31:0];
  assign mem_word = word_sel ? mem_rdata[63:32] : mem_rdata[31:0];
  // Left part: memory bytes go to the top, lower register bytes are kept.
  assign keep_left = `LAE_LOW24 >> {part_byte, 3'h0};
  assign left_word = (mem_word << {2'(`LAE_SIZE_PART_MAX - part_byte), 3'h0})
    | (old_value[31:0] & keep_left); // [RULE_08]
  // Right part: memory bytes go to the bottom, upper register bytes are kept.
  assign keep_right = ~(`LAE_ONES32 >> {part_byte, 3'h0});
  assign right_word = (mem_word >> {part_byte, 3'h0}) | (old_value[31:0] & keep_right); // [RULE_09]

  always_comb begin
    result = `LAE_ZERO64;
    unique case (kind)
      KIND_HALF_SIGNED: result = {{48{half[15]}}, half}; // [RULE_02]
      KIND_HALF_ZERO: result = {`LAE_ZERO48, half}; // [RULE_03]
      KIND_WORD_SIGNED: result = {mode64 ? {32{word[31]}} : `LAE_ZERO32, word}; // [RULE_06]
      KIND_WORD_LEFT: result = {{32{left_word[31]}}, left_word}; // [RULE_11]
      KIND_WORD_RIGHT: result = {{32{right_word[31]}}, right_word}; // [RULE_11]
      default: result = `LAE_ZERO64;
    endcase
  end

endmodule

// >>> design/lae_pkg.sv
// Types shared by the load align and extend data path.
package lae_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_SPARE = 4'b1000
  } lae_state_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_HALF_SIGNED = 3'h1,
    KIND_HALF_ZERO = 3'h2,
    KIND_UPPER_IMM = 3'h3,
    KIND_WORD_SIGNED = 3'h4,
    KIND_WORD_LEFT = 3'h5,
    KIND_WORD_RIGHT = 3'h6
  } lae_kind_t;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_ADDRESS = 3'h1,
    EXC_TLB_REFILL = 3'h2,
    EXC_TLB_INVALID = 3'h3,
    EXC_BUS = 3'h4
  } lae_exc_t;

endpackage

// >>> design/lae_top.sv
// Load data path: address forming, alignment check, memory request and result write-back.
// Operation
// [RULE_01] Virtual address is sign-extended 16-bit offset plus base register contents.
// [RULE_02] Signed halfword load sign-extends the fetched halfword into the target register.
// [RULE_03] Unsigned halfword load zero-fills the upper 48 target bits.
// [RULE_04] Halfword loads with address bit 0 set raise address error, no load.
// [RULE_05] Upper-immediate load puts immediate in bits 31:16, sign-extended, no memory access; code zero-fills bits 63:32 outside 64-bit mode.
// [RULE_06] Word load fetches 32 bits, sign-extended from bit 31 in 64-bit mode.
// [RULE_07] Word load with either low address bit set raises address error.
// [RULE_08] Left part load fills from the top byte down, keeping lower bytes.
// [RULE_09] Right part load fills from the bottom byte up, keeping upper bytes.
// [RULE_10] Part loads read one to four bytes from one aligned word.
// [RULE_11] Part loads replicate merged bit 31 into the upper 32 bits.
// [RULE_12] Part loads never raise an alignment address error.
// [RULE_13] Target register value is forwarded so back-to-back loads merge correctly.
// [RULE_14] Left part load with little-order memory clears low offset bits.
// [RULE_15] Right part load with big-order memory clears low offset bits.
// [RULE_16] Byte index is address 1:0 xor CPU order; word select bit 2 xor it.
// [RULE_17] Part load size code is bytes transferred minus one, 0 to 3.
// [RULE_18] Low offset is 0 or 4 little-order, 7 minus index big-order left.
// [RULE_19] Halfword loads request halfword size, offset flipped by user byte-order flip.
// [RULE_20] Memory faults are reported as exceptions instead of writing the target.
// [RULE_21] Opcode bits 31:26, base 25:21, target 20:16, offset 15:0.
`timescale 1ns/100ps
`include "lae_cfg.svh"

module lae_top import lae_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Instruction issue.
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [31:0] instr,
  output logic [4:0] base_reg_index,
  input wire logic [63:0] base_value,
  input wire logic [63:0] target_value,
  // Mode and byte order settings.
  input wire logic mode64,
  input wire logic cpu_byte_order_big,
  input wire logic memory_byte_order_big,
  input wire logic user_byte_order_flip,
  // Memory request.
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [63:0] mem_vaddr,
  output logic [2:0] mem_low_addr,
  output logic [2:0] transfer_size_code,
  // Memory answer.
  input wire logic mem_resp_valid,
  input wire logic [63:0] mem_rdata,
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic bus_error,
  // Register write-back.
  output logic wb_valid,
  output logic [4:0] target_reg,
  output logic [63:0] wb_data,
  // Exception report.
  output logic exc_valid,
  output lae_exc_t exc_code,
  output logic [63:0] exc_vaddr
);

  lae_state_t state_reg;
  lae_state_t state_next;
  lae_kind_t kind_reg;
  logic [63:0] vaddr_reg;
  logic [63:0] old_reg;
  logic [4:0] tgt_reg;
  logic mode64_reg;
  logic cpu_big_reg;
  logic mem_big_reg;
  logic flip_reg;
  logic wb_valid_reg;
  logic [4:0] wb_reg_reg;
  logic [63:0] wb_data_reg;
  logic exc_valid_reg;
  lae_exc_t exc_code_reg;
  logic [63:0] exc_vaddr_reg;

  // Decode of the issued instruction.
  logic [5:0] opcode;
  logic [4:0] issue_tgt;
  logic [15:0] imm;
  lae_kind_t issue_kind;
  logic [63:0] issue_vaddr;
  logic take;
  logic is_half;
  logic is_word;
  logic is_part;
  logic misaligned;
  logic [63:0] merge_old;
  logic [31:0] upper_word;
  logic [63:0] upper_value;

  assign opcode = instr[`LAE_OPC_HI:`LAE_OPC_LO]; // [RULE_21]
  assign base_reg_index = instr[`LAE_BASE_HI:`LAE_BASE_LO]; // [RULE_21]
  assign issue_tgt = instr[`LAE_TGT_HI:`LAE_TGT_LO]; // [RULE_21]
  assign imm = instr[`LAE_IMM_HI:`LAE_IMM_LO]; // [RULE_21]
  assign issue_kind = (opcode == `LAE_OPC_HALF_SIGNED) ? KIND_HALF_SIGNED
    : (opcode == `LAE_OPC_HALF_ZERO) ? KIND_HALF_ZERO
    : (opcode == `LAE_OPC_UPPER_IMM) ? KIND_UPPER_IMM
    : (opcode == `LAE_OPC_WORD_SIGNED) ? KIND_WORD_SIGNED
    : (opcode == `LAE_OPC_WORD_LEFT) ? KIND_WORD_LEFT
    : (opcode == `LAE_OPC_WORD_RIGHT) ? KIND_WORD_RIGHT
    : KIND_NONE;
  assign issue_vaddr = base_value + {{48{imm[15]}}, imm}; // [RULE_01]
  assign issue_ready = (state_reg == ST_IDLE);
  assign take = issue_valid && issue_ready && (issue_kind != KIND_NONE);
  assign is_half = (issue_kind == KIND_HALF_SIGNED) || (issue_kind == KIND_HALF_ZERO);
  assign is_word = (issue_kind == KIND_WORD_SIGNED);
  assign is_part = (issue_kind == KIND_WORD_LEFT) || (issue_kind == KIND_WORD_RIGHT);
  // Part loads take no alignment check at all.
  assign misaligned = (is_half && issue_vaddr[0]) // [RULE_04]
    || (is_word && (issue_vaddr[1:0] != 2'h0)); // [RULE_07] [RULE_12]
  // The register file has not yet seen a write made in the previous cycle.
  assign merge_old = (wb_valid_reg && (wb_reg_reg == issue_tgt)) ? wb_data_reg : target_value; // [RULE_13]
  assign upper_word = {imm, `LAE_ZERO16};
  assign upper_value = {mode64 ? {32{upper_word[31]}} : `LAE_ZERO32, upper_word}; // [RULE_05]

  // Memory request fields, formed from the held load.
  logic [1:0] part_byte;
  logic word_sel;
  logic [2:0] flip3;
  logic [2:0] dbl_byte;
  logic [2:0] part_ofs;
  logic [2:0] req_low;
  logic [2:0] req_size;
  logic req_left;
  logic req_right;

  assign req_left = (kind_reg == KIND_WORD_LEFT);
  assign req_right = (kind_reg == KIND_WORD_RIGHT);
  assign part_byte = vaddr_reg[1:0] ^ {2{cpu_big_reg}}; // [RULE_16]
  assign word_sel = vaddr_reg[2] ^ cpu_big_reg; // [RULE_16]
  assign flip3 = {3{flip_reg}};
  // Byte position of halfword and word data inside the returned doubleword.
  assign dbl_byte = (kind_reg == KIND_WORD_SIGNED) ? (vaddr_reg[2:0] ^ {cpu_big_reg, 2'h0})
    : (vaddr_reg[2:0] ^ {cpu_big_reg, cpu_big_reg, 1'b0});
  assign part_ofs = req_left ? (mem_big_reg ? (`LAE_OFS_TOP - {word_sel, part_byte})
      : {word_sel, 2'h0}) // [RULE_14] [RULE_18]
    : (mem_big_reg ? {~word_sel, 2'h0} : {word_sel, part_byte}); // [RULE_15] [RULE_18]
  assign req_low = (req_left || req_right) ? (part_ofs ^ flip3)
    : (kind_reg == KIND_WORD_SIGNED) ? (vaddr_reg[2:0] ^ {flip_reg, 2'h0})
    : (vaddr_reg[2:0] ^ {flip_reg, flip_reg, 1'b0}); // [RULE_19]
  // Part loads stay inside one aligned word, so one to four bytes move.
  assign req_size = req_left ? {1'b0, part_byte} // [RULE_10] [RULE_17]
    : req_right ? {1'b0, 2'(`LAE_SIZE_PART_MAX - part_byte)} // [RULE_17]
    : (kind_reg == KIND_WORD_SIGNED) ? `LAE_SIZE_WORD
    : `LAE_SIZE_HALF; // [RULE_19]

  assign mem_req_valid = (state_reg == ST_REQ);
  assign mem_vaddr = vaddr_reg;
  assign mem_low_addr = req_low;
  assign transfer_size_code = req_size;

  // Answer handling.
  logic [63:0] merged;
  logic fault;
  lae_exc_t fault_code;

  lae_merge merge_unit (
    .kind(kind_reg),
    .dbl_byte(dbl_byte),
    .part_byte(part_byte),
    .word_sel(word_sel),
    .mode64(mode64_reg),
    .mem_rdata(mem_rdata),
    .old_value(old_reg),
    .result(merged)
  );

  assign fault = tlb_refill || tlb_invalid || bus_error;
  assign fault_code = tlb_refill ? EXC_TLB_REFILL : tlb_invalid ? EXC_TLB_INVALID : EXC_BUS;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take && !misaligned && (issue_kind != KIND_UPPER_IMM)) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (mem_req_ready) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_resp_valid) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Load description held while the request is outstanding.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      kind_reg <= KIND_NONE;
      vaddr_reg <= `LAE_ZERO64;
      old_reg <= `LAE_ZERO64;
      tgt_reg <= `LAE_REG_ZERO;
      mode64_reg <= 1'b0;
      cpu_big_reg <= 1'b0;
      mem_big_reg <= 1'b0;
      flip_reg <= 1'b0;
    end else if (take) begin
      kind_reg <= issue_kind;
      vaddr_reg <= issue_vaddr;
      old_reg <= merge_old; // [RULE_13]
      tgt_reg <= issue_tgt;
      mode64_reg <= mode64;
      cpu_big_reg <= cpu_byte_order_big;
      mem_big_reg <= memory_byte_order_big;
      flip_reg <= user_byte_order_flip;
    end
  end

  // Write-back pulse.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb_valid_reg <= 1'b0;
      wb_reg_reg <= `LAE_REG_ZERO;
      wb_data_reg <= `LAE_ZERO64;
    end else if (take && (issue_kind == KIND_UPPER_IMM)) begin
      wb_valid_reg <= 1'b1; // [RULE_05]
      wb_reg_reg <= issue_tgt;
      wb_data_reg <= upper_value;
    end else if ((state_reg == ST_WAIT) && mem_resp_valid && !fault) begin
      wb_valid_reg <= 1'b1;
      wb_reg_reg <= tgt_reg;
      wb_data_reg <= merged;
    end else begin
      wb_valid_reg <= 1'b0;
    end
  end

  // Exception pulse; a faulting load never writes its target.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      exc_valid_reg <= 1'b0;
      exc_code_reg <= EXC_NONE;
      exc_vaddr_reg <= `LAE_ZERO64;
    end else if (take && misaligned) begin
      exc_valid_reg <= 1'b1; // [RULE_04] [RULE_07]
      exc_code_reg <= EXC_ADDRESS;
      exc_vaddr_reg <= issue_vaddr;
    end else if ((state_reg == ST_WAIT) && mem_resp_valid && fault) begin
      exc_valid_reg <= 1'b1; // [RULE_20]
      exc_code_reg <= fault_code;
      exc_vaddr_reg <= vaddr_reg;
    end else begin
      exc_valid_reg <= 1'b0;
    end
  end

  assign wb_valid = wb_valid_reg;
  assign target_reg = wb_reg_reg;
  assign wb_data = wb_data_reg;
  assign exc_valid = exc_valid_reg;
  assign exc_code = exc_code_reg;
  assign exc_vaddr = exc_vaddr_reg;

  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence seq_take_half_odd;
    take && is_half && issue_vaddr[0];
  endsequence

  sequence seq_take_word_odd;
    take && is_word && (issue_vaddr[1:0] != 2'h0);
  endsequence

  sequence seq_addr_fault;
    exc_valid && (exc_code == EXC_ADDRESS) && !wb_valid && !mem_req_valid;
  endsequence

  sequence seq_mem_fault;
    (state_reg == ST_WAIT) && mem_resp_valid && fault;
  endsequence

  AST_HALF_ALIGN: assert property (seq_take_half_odd |=> seq_addr_fault) // [RULE_04]
    else $error("Odd halfword address did not raise an address error.");

  AST_WORD_ALIGN: assert property (seq_take_word_odd |=> seq_addr_fault) // [RULE_07]
    else $error("Unaligned word address did not raise an address error.");

  AST_PART_NO_ALIGN: assert property (take && is_part |=> !exc_valid && mem_req_valid) // [RULE_12]
    else $error("Part load raised an alignment error or skipped memory.");

  AST_UPPER_IMM: assert property (take && (issue_kind == KIND_UPPER_IMM) && mode64
    |=> wb_valid && (wb_data == {{32{$past(imm[15])}}, $past(imm), 16'h0000}) && !mem_req_valid) // [RULE_05]
    else $error("Upper-immediate result wrong or memory touched.");

  AST_PART_SIZE: assert property (mem_req_valid && req_left // [RULE_17]
    |-> transfer_size_code == {1'b0, mem_vaddr[1:0] ^ {2{cpu_big_reg}}})
    else $error("Left part size code does not match start byte.");

  AST_LEFT_LITTLE: assert property (mem_req_valid && req_left && !mem_big_reg && !flip_reg
    |-> mem_low_addr[1:0] == 2'h0) // [RULE_14]
    else $error("Left part load to little-order memory left low offset bits set.");

  AST_RIGHT_BIG: assert property (mem_req_valid && req_right && mem_big_reg && !flip_reg
    |-> mem_low_addr[1:0] == 2'h0) // [RULE_15]
    else $error("Right part load to big-order memory left low offset bits set.");

  AST_FAULT_REPORT: assert property (seq_mem_fault |=> exc_valid && !wb_valid && (state_reg == ST_IDLE)) // [RULE_20]
    else $error("Memory fault was not reported or the target was written.");

  AST_HALF_ZERO: assert property ((state_reg == ST_WAIT) && mem_resp_valid && !fault
    && (kind_reg == KIND_HALF_ZERO) |=> wb_valid && (wb_data[63:16] == 48'h0)) // [RULE_03]
    else $error("Unsigned halfword load left upper bits nonzero.");

  AST_PART_SIGN: assert property ((state_reg == ST_WAIT) && mem_resp_valid && !fault && (req_left || req_right)
    |=> wb_valid && (wb_data[63:32] == {32{wb_data[31]}})) // [RULE_11]
    else $error("Part load upper word is not a copy of bit 31.");

  AST_FORWARD: assert property (take && wb_valid && (target_reg == issue_tgt) |=> old_reg == $past(wb_data)) // [RULE_13]
    else $error("Previous load result was not forwarded into the merge.");

  AST_HALF_REQ: assert property (mem_req_valid && ((kind_reg == KIND_HALF_SIGNED) || (kind_reg == KIND_HALF_ZERO)) // [RULE_19]
    |-> (transfer_size_code == `LAE_SIZE_HALF)
    && (mem_low_addr == (mem_vaddr[2:0] ^ {flip_reg, flip_reg, 1'b0})))
    else $error("Halfword request size or low offset is wrong.");

  AST_WORD_SIGN: assert property ((state_reg == ST_WAIT) && mem_resp_valid && !fault // [RULE_06]
    && (kind_reg == KIND_WORD_SIGNED) && mode64_reg |=> wb_valid && (wb_data[63:32] == {32{wb_data[31]}}))
    else $error("Word load in 64-bit mode did not sign-extend.");

  AST_EXC_NO_WB: assert property (exc_valid |-> !wb_valid) // [RULE_20]
    else $error("Exception and register write happened together.");

endmodule

// >>> test/lae_mem_model.sv
// Behavioural translation and memory model facing the load data path.
`timescale 1ns/100ps

module lae_mem_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Request and answer.
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  output logic mem_resp_valid,
  output logic [63:0] mem_rdata,
  output logic tlb_refill,
  output logic tlb_invalid,
  output logic bus_error,
  // Answer shaping chosen by the bench.
  input wire logic [1:0] ready_delay,
  input wire logic [1:0] resp_delay,
  input wire logic [63:0] fill_data,
  input wire logic [2:0] fault_mask
);
  int st = 0;
  int cnt = 0;
  logic rdy;
  logic rsp;
  initial begin
    mem_req_ready = 1'b0;
    mem_resp_valid = 1'b0;
    mem_rdata = 64'h0;
    {bus_error, tlb_invalid, tlb_refill} = 3'h7;
  end
  // Outside an answer the data and fault lines toggle so stale values never look valid.
  always @(posedge clock) begin
    #1;
    rdy = 1'b0;
    rsp = 1'b0;
    if (reset_n !== 1'b1) begin
      st = 0;
    end else if (st == 0 && mem_req_valid === 1'b1) begin
      st = 1;
      cnt = ready_delay;
    end else if (st == 2) begin
      st = 3;
      cnt = resp_delay;
    end
    if (st == 1 || st == 3) begin
      if (cnt > 0) begin
        cnt--;
      end else if (st == 1) begin
        rdy = 1'b1;
        st = 2;
      end else begin
        rsp = 1'b1;
        st = 0;
      end
    end
    mem_req_ready = rdy;
    mem_resp_valid = rsp;
    mem_rdata = rsp ? fill_data : ~mem_rdata;
    {bus_error, tlb_invalid, tlb_refill} = rsp ? fault_mask : ~{bus_error, tlb_invalid, tlb_refill};
  end
endmodule

// >>> test/lae_top_test.sv
// Self-checking bench for the load data path with a behavioural result model.
`timescale 1ns/100ps

module lae_top_test import lae_pkg::*; ;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic issue_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] base_value = 64'h0;
  logic [63:0] target_value = 64'h0;
  logic mode64 = 1'b0;
  logic cpu_byte_order_big = 1'b0;
  logic memory_byte_order_big = 1'b0;
  logic user_byte_order_flip = 1'b0;
  logic [1:0] ready_delay = 2'h0;
  logic [1:0] resp_delay = 2'h0;
  logic [63:0] fill_data = 64'h0;
  logic [2:0] fault_mask = 3'h0;
  logic issue_ready, mem_req_valid, mem_req_ready, mem_resp_valid;
  logic tlb_refill, tlb_invalid, bus_error, wb_valid, exc_valid;
  logic [4:0] base_reg_index, target_reg;
  logic [2:0] mem_low_addr, transfer_size_code;
  logic [63:0] mem_vaddr, mem_rdata, wb_data, exc_vaddr;
  lae_exc_t exc_code;
  logic [63:0] gpr [32];
  logic [5:0] ops [6] = '{6'h21, 6'h25, 6'h0f, 6'h23, 6'h22, 6'h26};
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'heea8;

  lae_top u_dut (.clock, .reset_n, .issue_valid, .issue_ready, .instr, .base_reg_index, .base_value,
    .target_value, .mode64, .cpu_byte_order_big, .memory_byte_order_big, .user_byte_order_flip,
    .mem_req_valid, .mem_req_ready, .mem_vaddr, .mem_low_addr, .transfer_size_code, .mem_resp_valid,
    .mem_rdata, .tlb_refill, .tlb_invalid, .bus_error, .wb_valid, .target_reg, .wb_data, .exc_valid,
    .exc_code, .exc_vaddr);

  lae_mem_model u_mem (.clock, .reset_n, .mem_req_valid, .mem_req_ready, .mem_resp_valid, .mem_rdata,
    .tlb_refill, .tlb_invalid, .bus_error, .ready_delay, .resp_delay, .fill_data, .fault_mask);

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  // Issues one load, predicts its outcome from the register model and compares every result.
  task automatic do_load(input logic [5:0] opc, input logic [4:0] tgt, input logic [2:0] low,
    input logic [2:0] fm, input bit stale);
    logic [63:0] base, va, dbl, exp;
    logic [31:0] w32, t;
    logic [15:0] imm;
    logic [4:0] bidx;
    logic [2:0] b8, lo, size;
    logic [1:0] b;
    logic w, mem;
    int exc, k;
    imm = $random(seed);
    bidx = $random(seed);
    base = {$random(seed), $random(seed)};
    va = base + {{48{imm[15]}}, imm};
    base = base - {61'h0, va[2:0]} + {61'h0, low};
    va = base + {{48{imm[15]}}, imm};
    dbl = {$random(seed), $random(seed)};
    b = va[1:0] ^ {2{cpu_byte_order_big}};
    w = va[2] ^ cpu_byte_order_big;
    w32 = dbl[32 * w +: 32];
    t = 32'h0;
    exc = 0;
    mem = 1'b1;
    size = 3'h3;
    lo = va[2:0] ^ {user_byte_order_flip, 2'h0};
    case (opc)
      6'h21, 6'h25: begin
        exc = va[0];
        size = 3'h1;
        lo = va[2:0] ^ {{2{user_byte_order_flip}}, 1'b0};
        b8 = va[2:0] ^ {{2{cpu_byte_order_big}}, 1'b0};
        exp = {48'h0, dbl[8 * b8 +: 16]};
        if (opc == 6'h21) exp[63:16] = {48{exp[15]}};
      end
      6'h0f: begin
        mem = 1'b0;
        exp = {{32{mode64 & imm[15]}}, imm, 16'h0};
      end
      6'h23: begin
        exc = va[1:0] != 2'h0;
        b8 = va[2:0] ^ {cpu_byte_order_big, 2'h0};
        w32 = dbl[8 * b8 +: 32];
        exp = {{32{mode64 & w32[31]}}, w32};
      end
      6'h22: begin
        size = {1'b0, b};
        lo = memory_byte_order_big ? 3'h7 - {w, b} : {w, 2'h0};
        t = (w32 << (8 * (3 - b))) | (gpr[tgt][31:0] & (32'hffff_ffff >> (8 * (b + 1))));
      end
      default: begin
        size = 3'h3 - b;
        lo = memory_byte_order_big ? {~w, 2'h0} : {w, b};
        t = (w32 >> (8 * b)) | (gpr[tgt][31:0] & ~(32'hffff_ffff >> (8 * b)));
      end
    endcase
    if (opc == 6'h22 || opc == 6'h26) begin
      lo = lo ^ {3{user_byte_order_flip}};
      exp = {{32{t[31]}}, t};
    end
    if (mem && exc == 0 && fm != 3'h0) exc = fm[0] ? 2 : (fm[1] ? 3 : 4);
    fill_data = dbl;
    fault_mask = fm;
    ready_delay = $random(seed);
    resp_delay = $random(seed);
    k = 0;
    while (issue_ready !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    issue_valid = 1'b1;
    instr = {opc, bidx, tgt, imm};
    base_value = base;
    target_value = stale ? ~gpr[tgt] : gpr[tgt];
    #1;
    check("base_reg_index", base_reg_index, bidx);
    tick();
    issue_valid = 1'b0;
    instr = ~instr;
    base_value = ~base;
    target_value = {$random(seed), $random(seed)};
    if (mem && exc != 1) begin
      check("mem_req_valid", mem_req_valid, 1);
      check("issue_ready", issue_ready, 0);
      check("mem_vaddr", mem_vaddr, va);
      check("mem_low_addr", mem_low_addr, lo);
      check("transfer_size_code", transfer_size_code, size);
    end
    k = 0;
    while (wb_valid !== 1'b1 && exc_valid !== 1'b1 && k < 30) begin
      tick();
      k++;
    end
    if (!mem || exc == 1) begin
      check("latency", k, 0);
      check("mem_req_valid", mem_req_valid, 0);
    end
    check("exc_valid", exc_valid, exc != 0);
    check("wb_valid", wb_valid, exc == 0);
    if (exc != 0) begin
      check("exc_code", exc_code, exc);
      check("exc_vaddr", exc_vaddr, va);
    end else begin
      check("target_reg", target_reg, tgt);
      check("wb_data", wb_data, exp);
      gpr[tgt] = exp;
    end
  endtask

  initial begin
    #(4 * 20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 32; i++) gpr[i] = {$random(seed), $random(seed)};
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    for (int o = 0; o < 6; o++) begin
      for (int c = 0; c < 64; c++) begin
        {cpu_byte_order_big, memory_byte_order_big, user_byte_order_flip} = c[5:3];
        mode64 = $random(seed);
        do_load(ops[o], 5'($random(seed)), c[2:0], 3'h0, 1'b0);
      end
    end
    $display("test orders and alignments done");
    for (int f = 1; f < 8; f++) begin
      do_load(6'h23, 5'h3, 3'h0, f[2:0], 1'b0);
      do_load(6'h22, 5'h3, f[2:0], f[2:0], 1'b0);
    end
    $display("test memory faults done");
    for (int j = 0; j < 8; j++) begin
      do_load(6'h23, 5'h9, 3'h4, 3'h0, 1'b0);
      do_load(6'h22, 5'h9, j[2:0], 3'h0, 1'b1);
      do_load(6'h26, 5'h9, ~j[2:0], 3'h0, 1'b1);
    end
    $display("test forwarding done");
    issue_valid = 1'b1;
    instr = {6'h24, 26'h0};
    tick();
    issue_valid = 1'b0;
    repeat (6) begin
      check("dropped", wb_valid | exc_valid | mem_req_valid, 0);
      tick();
    end
    $display("test unsupported opcode done");
    print_verdict();
  end
endmodule
